/* hw/earth_fault_event_recorder.sv */
// measurement display and disturbance recorder of an earth-fault module
`default_nettype none

// What this block does
// [R1] checksum sums weights of switches set
// [R2] selected quantity on digits, lamp shows which
// [R3] voltage shown as percent, span 0..106
// [R4] current shown as percent, span 0..210
// [R5] angle is basic minus current, wrapped
// [R6] angle view shows dash when either input is below 0.3 percent
// [R7] register view: number left, value right
// [R8] stage start updates records, operate alone does not
// [R9] update shifts history, oldest lost
// [R10] five entries: main plus four subregisters
// [R11] registers 1-3 hold voltage, current, angle
// [R12] start only: values at start captured
// [R13] operate: values at operate captured
// [R14] commit only after all stages reset
// [R15] registers 4-6 hold relative start durations
// [R16] duration in percent, 100 on operate
// [R17] subregister five counts starts 0..255
// [R18] start counter saturates at 255
// [R19] panel, external or serial clear records
// [R20] supply loss clears unless retention set
module earth_fault_event_recorder
	import recorder_pkg::*;
#(
	parameter int TICK_LEN_W = TICK_W
)(
	input  wire logic                     sys_clk_i,
	input  wire logic                     rst_n_i,
	input  wire logic [MEAS_W-1:0]        residual_voltage_i,
	input  wire logic [MEAS_W-1:0]        neutral_current_i,
	input  wire logic signed [ANG_W-1:0]  basic_angle_i,
	input  wire logic signed [ANG_W-1:0]  current_angle_i,
	input  wire logic [N_STAGES-1:0]      stage_start_i,
	input  wire logic [N_STAGES-1:0]      stage_operate_i,
	input  wire logic [TICK_LEN_W-1:0]    residual_stage_operate_time_i,
	input  wire logic [TICK_LEN_W-1:0]    first_stage_operate_time_i,
	input  wire logic [TICK_LEN_W-1:0]    second_stage_operate_time_i,
	input  wire logic [1:0]               display_select_i,
	input  wire logic [2:0]               register_select_i,
	input  wire logic [2:0]               subregister_select_i,
	input  wire logic                     panel_clear_i,
	input  wire logic                     external_clear_i,
	input  wire logic                     serial_clear_i,
	input  wire logic                     supply_lost_i,
	input  wire logic                     record_retention_switch_i,
	input  wire logic [N_SW-1:0]          function_switch_group_one_i,
	output logic      [3:0]               display_address_o,
	output logic      [DISP_W-1:0]        display_value_o,
	output logic                          display_dash_o,
	output logic      [2:0]               indicator_lamp_o,
	output logic      [N_SW-1:0]          checksum_o
);

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------
	// tenths of percent to whole percent, clipped to the span
	function automatic logic [PCT_W-1:0] to_pct(
		input logic [MEAS_W-1:0] tenths,
		input logic [PCT_W-1:0]  span
	);
		logic [MEAS_W+15:0] prod;
		logic [MEAS_W-1:0]  whole;

		// times 0.1
		prod  = tenths * DIV10_MUL;
		whole = prod[DIV10_SHIFT +: MEAS_W];

		// clip to span
		if (whole > MEAS_W'(span)) begin
			to_pct = span;
		end else begin
			to_pct = whole[PCT_W-1:0];
		end
	endfunction

	// difference of two angles folded into the half turn
	function automatic logic [ANG_W-1:0] wrap_angle(
		input logic signed [ANG_W-1:0] ref_ang,
		input logic signed [ANG_W-1:0] cur_ang
	);
		logic signed [DISP_W-1:0] d;

		// fold once
		d = DISP_W'(ref_ang) - DISP_W'(cur_ang);
		if (d > ANG_HALF) begin
			d = d - ANG_FULL;
		end else if (d < -ANG_HALF) begin
			d = d + ANG_FULL;
		end

		wrap_angle = d[ANG_W-1:0];
	endfunction

	// unsigned percent widened for the display
	function automatic logic [DISP_W-1:0] widen_pct(
		input logic [PCT_W-1:0] v
	);
		// zero fill
		widen_pct = {{(DISP_W-PCT_W){1'b0}}, v};
	endfunction

	// signed angle widened for the display
	function automatic logic [DISP_W-1:0] widen_ang(
		input logic [ANG_W-1:0] v
	);
		// sign fill
		widen_ang = {{(DISP_W-ANG_W){v[ANG_W-1]}}, v};
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	rec_state_s_t s_ff;
	rec_state_s_t nxt_s;

	// live values
	logic [PCT_W-1:0]              live_volt;
	logic [PCT_W-1:0]              live_curr;
	logic [ANG_W-1:0]              live_ang;
	logic                          live_low;
	logic [N_SW-1:0]               sum_w;
	logic [N_STAGES-1:0][PCT_W-1:0] dur_pct;
	logic [N_STAGES-1:0][TICK_LEN_W-1:0] tick_len;

	// event control
	logic                          begin_evt;
	logic                          clear_all;

	// ----------------------------------------------------------------
	// live measurements
	// ----------------------------------------------------------------
	// percentages
	assign live_volt = to_pct(residual_voltage_i, VOLT_SPAN_PCT); // [R3]
	assign live_curr = to_pct(neutral_current_i, CURR_SPAN_PCT); // [R4]

	// angle, weak test
	assign live_ang  = wrap_angle(basic_angle_i, current_angle_i); // [R5]
	assign live_low  = (residual_voltage_i < MIN_TENTHS) ||
		(neutral_current_i < MIN_TENTHS); // [R6]

	// timers restart
	assign begin_evt = (s_ff.state == ST_IDLE) && (|stage_start_i);

	// any clear source
	assign clear_all = panel_clear_i || external_clear_i ||
		serial_clear_i || // [R19]
		(supply_lost_i && !record_retention_switch_i); // [R20]

	// ----------------------------------------------------------------
	// switchgroup checksum
	// ----------------------------------------------------------------
	// weighted sum
	switch_checksum u_checksum (
		.switches_i (function_switch_group_one_i),
		.checksum_o (sum_w)
	);

	// ----------------------------------------------------------------
	// start duration timers, one per stage
	// ----------------------------------------------------------------
	// stage order
	assign tick_len[0] = residual_stage_operate_time_i;
	assign tick_len[1] = first_stage_operate_time_i;
	assign tick_len[2] = second_stage_operate_time_i;

	generate
		for (genvar g = 0; g < N_STAGES; g++) begin : g_timer
			timer_if tif ();
			// stage inputs
			assign tif.begin_evt = begin_evt;
			assign tif.start     = stage_start_i[g];
			assign tif.operate   = stage_operate_i[g];
			assign tif.tick_len  = TICK_W'(tick_len[g]);
			assign dur_pct[g]    = tif.pct;

			start_timer u_timer (
				.sys_clk_i (sys_clk_i),
				.rst_n_i   (rst_n_i),
				.tif       (tif)
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// recording and display
	// ----------------------------------------------------------------
	always_comb begin
		nxt_s = s_ff;
		// edge history
		nxt_s.start_prev = stage_start_i;
		nxt_s.op_prev    = stage_operate_i;
		// checksum
		nxt_s.checksum   = sum_w; // [R1]

		// start counters
		// rising edge, saturating
		for (int k = 0; k < N_STAGES; k++) begin
			if (stage_start_i[k] && !s_ff.start_prev[k] &&
				s_ff.start_cnt[k] != START_CNT_MAX) begin // [R18]
				nxt_s.start_cnt[k] = s_ff.start_cnt[k] + 1'b1; // [R17]
			end
		end

		// event sequencing
		unique case (s_ff.state)
			ST_IDLE: begin
				// event opens
				if (|stage_start_i) begin // [R8]
					nxt_s.state    = ST_EVENT;
					nxt_s.locked   = 1'b0;
					nxt_s.cap_volt = live_volt; // [R12]
					nxt_s.cap_curr = live_curr;
					nxt_s.cap_ang  = live_ang;
				end
			end
			ST_EVENT: begin
				// first operate
				if (!s_ff.locked &&
					(|(stage_operate_i & ~s_ff.op_prev))) begin
					nxt_s.locked   = 1'b1;
					nxt_s.cap_volt = live_volt; // [R13]
					nxt_s.cap_curr = live_curr;
					nxt_s.cap_ang  = live_ang;
				end

				// all reset: commit
				if (!(|stage_start_i) && !(|stage_operate_i)) begin // [R14]
					nxt_s.state = ST_IDLE;
					// shift history
					nxt_s.hist_volt = {s_ff.hist_volt[HIST_DEPTH-2:0],
						s_ff.cap_volt}; // [R9]
					nxt_s.hist_curr = {s_ff.hist_curr[HIST_DEPTH-2:0],
						s_ff.cap_curr}; // [R11]
					nxt_s.hist_ang = {s_ff.hist_ang[HIST_DEPTH-2:0],
						s_ff.cap_ang};

					for (int k = 0; k < N_STAGES; k++) begin
						nxt_s.hist_dur[k] = {
							s_ff.hist_dur[k][HIST_DEPTH-2:0],
							dur_pct[k]}; // [R15]
					end
				end
			end
		endcase

		// clearing of all six registers
		// wins over commit
		if (clear_all) begin
			nxt_s.hist_volt = '0;
			nxt_s.hist_curr = '0;
			nxt_s.hist_ang  = '0;
			nxt_s.hist_dur  = '0;
			nxt_s.start_cnt = '0; // [R19]
		end

		// display
		// defaults
		nxt_s.disp_addr = '0;
		nxt_s.disp_dash = 1'b0;
		nxt_s.disp_val  = '0;
		nxt_s.lamp      = LAMP_NONE;
		unique case (display_select_i)
			SHOW_VOLT: begin
				nxt_s.lamp     = LAMP_VOLT; // [R2]
				nxt_s.disp_val = widen_pct(live_volt);
			end

			SHOW_CURR: begin
				nxt_s.lamp     = LAMP_CURR;
				nxt_s.disp_val = widen_pct(live_curr);
			end

			SHOW_ANG: begin
				nxt_s.lamp = LAMP_ANG;
				// weak input
				if (live_low) begin
					nxt_s.disp_dash = 1'b1; // [R6]
				end else begin
					nxt_s.disp_val = widen_ang(live_ang);
				end
			end

			SHOW_REG: begin
				nxt_s.disp_addr = {1'b0, register_select_i}; // [R7]
				// refused numbers
				if (register_select_i < REG_VOLT ||
					register_select_i > REG_LAST) begin
					nxt_s.disp_dash = 1'b1;
				end else if (subregister_select_i == SUB_COUNT) begin
					// count: regs 4..6
					if (register_select_i >= REG_DUR0) begin
						nxt_s.disp_val = widen_pct(s_ff.start_cnt[
							register_select_i - REG_DUR0]); // [R17]
					end else begin
						nxt_s.disp_dash = 1'b1;
					end
				end else if (subregister_select_i > SUB_COUNT) begin
					nxt_s.disp_dash = 1'b1;
				end else begin
					// newest first
					unique case (register_select_i)
						REG_VOLT: nxt_s.disp_val = widen_pct(
							s_ff.hist_volt[subregister_select_i]); // [R10]
						REG_CURR: nxt_s.disp_val = widen_pct(
							s_ff.hist_curr[subregister_select_i]);
						REG_ANG: nxt_s.disp_val = widen_ang(
							s_ff.hist_ang[subregister_select_i]);
						default: nxt_s.disp_val = widen_pct(
							s_ff.hist_dur[register_select_i - REG_DUR0]
							[subregister_select_i]);
					endcase
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// sync reset
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// from state
	assign display_address_o = s_ff.disp_addr;
	assign display_value_o   = s_ff.disp_val;
	assign display_dash_o    = s_ff.disp_dash;
	assign indicator_lamp_o  = s_ff.lamp;
	assign checksum_o        = s_ff.checksum;

endmodule
`default_nettype wire

/* hw/recorder_pkg.sv */
// shared constants and types of the earth-fault event recorder
`default_nettype none
package recorder_pkg;

	// ----------------------------------------------------------------
	// widths and depths
	// ----------------------------------------------------------------
	localparam int N_STAGES   = 3;
	localparam int HIST_DEPTH = 5;
	localparam int N_SW       = 8;
	localparam int MEAS_W     = 12;
	localparam int PCT_W      = 8;
	localparam int ANG_W      = 9;
	localparam int DISP_W     = 10;
	localparam int TICK_W     = 16;

	// ----------------------------------------------------------------
	// measuring spans, thresholds, scaling
	// ----------------------------------------------------------------
	localparam logic [PCT_W-1:0]  VOLT_SPAN_PCT = 8'h6A;
	localparam logic [PCT_W-1:0]  CURR_SPAN_PCT = 8'hD2;
	localparam logic [MEAS_W-1:0] MIN_TENTHS    = 12'h003;
	localparam logic [15:0]       DIV10_MUL     = 16'h199A;
	localparam int                DIV10_SHIFT   = 16;
	localparam logic signed [DISP_W-1:0] ANG_HALF = 10'sh0B4;
	localparam logic signed [DISP_W-1:0] ANG_FULL = 10'sh168;
	localparam logic [PCT_W-1:0]  DUR_FULL_PCT  = 8'h64;
	localparam logic [PCT_W-1:0]  START_CNT_MAX = 8'hFF;

	// ----------------------------------------------------------------
	// display selection and register numbering
	// ----------------------------------------------------------------
	localparam logic [1:0] SHOW_VOLT = 2'h0;
	localparam logic [1:0] SHOW_CURR = 2'h1;
	localparam logic [1:0] SHOW_ANG  = 2'h2;
	localparam logic [1:0] SHOW_REG  = 2'h3;
	localparam logic [2:0] LAMP_VOLT = 3'h1;
	localparam logic [2:0] LAMP_CURR = 3'h2;
	localparam logic [2:0] LAMP_ANG  = 3'h4;
	localparam logic [2:0] LAMP_NONE = 3'h0;
	localparam logic [2:0] REG_VOLT  = 3'h1;
	localparam logic [2:0] REG_CURR  = 3'h2;
	localparam logic [2:0] REG_ANG   = 3'h3;
	localparam logic [2:0] REG_DUR0  = 3'h4;
	localparam logic [2:0] REG_LAST  = 3'h6;
	localparam logic [2:0] SUB_COUNT = 3'h5;

	// ----------------------------------------------------------------
	// state types
	// ----------------------------------------------------------------
	typedef enum logic {ST_IDLE, ST_EVENT} rec_state_t;

	typedef struct packed {
		logic [TICK_W-1:0] presc;
		logic [PCT_W-1:0]  pct;
	} timer_state_t;

	typedef struct packed {
		rec_state_t                             state;
		logic                                   locked;
		logic [PCT_W-1:0]                       cap_volt;
		logic [PCT_W-1:0]                       cap_curr;
		logic [ANG_W-1:0]                       cap_ang;
		logic [N_STAGES-1:0]                    start_prev;
		logic [N_STAGES-1:0]                    op_prev;
		logic [HIST_DEPTH-1:0][PCT_W-1:0]       hist_volt;
		logic [HIST_DEPTH-1:0][PCT_W-1:0]       hist_curr;
		logic [HIST_DEPTH-1:0][ANG_W-1:0]       hist_ang;
		logic [N_STAGES-1:0][HIST_DEPTH-1:0][PCT_W-1:0] hist_dur;
		logic [N_STAGES-1:0][PCT_W-1:0]         start_cnt;
		logic [3:0]                             disp_addr;
		logic [DISP_W-1:0]                      disp_val;
		logic                                   disp_dash;
		logic [2:0]                             lamp;
		logic [N_SW-1:0]                        checksum;
	} rec_state_s_t;

endpackage
`default_nettype wire

/* hw/timer_if.sv */
// carrier between the recorder and one start duration timer
`default_nettype none
interface timer_if;
	import recorder_pkg::*;
	logic                begin_evt;
	logic                start;
	logic                operate;
	logic [TICK_W-1:0]   tick_len;
	logic [PCT_W-1:0]    pct;

	modport timer (
		input  begin_evt,
		input  start,
		input  operate,
		input  tick_len,
		output pct
	);
	modport recorder (
		output begin_evt,
		output start,
		output operate,
		output tick_len,
		input  pct
	);
endinterface
`default_nettype wire

/* hw/switch_checksum.sv */
// weighted sum of one switchgroup
`default_nettype none
module switch_checksum
	import recorder_pkg::*;
(
	input  wire logic [N_SW-1:0] switches_i,
	output logic      [N_SW-1:0] checksum_o
);
	always_comb begin
		checksum_o = '0;
		for (int k = 0; k < N_SW; k++) begin
			if (switches_i[k]) begin
				checksum_o = checksum_o + N_SW'(1 << k); // [R1]
			end
		end
	end
endmodule
`default_nettype wire

/* hw/start_timer.sv */
// start duration of one stage as percent of its operate time
`default_nettype none
module start_timer
	import recorder_pkg::*;
(
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	timer_if.timer    tif
);
	timer_state_t s_ff;
	timer_state_t nxt_s;

	assign tif.pct = s_ff.pct;

	always_comb begin
		nxt_s = s_ff;
		if (tif.begin_evt) begin
			nxt_s = '0;
		end else if (tif.operate) begin
			nxt_s.pct = DUR_FULL_PCT; // [R16]
		end else if (tif.start && s_ff.pct < DUR_FULL_PCT) begin
			nxt_s.presc = s_ff.presc + 1'b1;
			if (s_ff.presc + 1'b1 >= tif.tick_len) begin
				nxt_s.presc = '0;
				nxt_s.pct   = s_ff.pct + 1'b1; // [R15]
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule
`default_nettype wire

/* test/recorder_sva.sv */
// port checker of the earth-fault event recorder
`default_nettype none
module recorder_sva
	import recorder_pkg::*;
#(
	parameter int TICK_LEN_W = TICK_W
)(
	input wire logic                    sys_clk_i,
	input wire logic                    rst_n_i,
	input wire logic [MEAS_W-1:0]       residual_voltage_i,
	input wire logic [MEAS_W-1:0]       neutral_current_i,
	input wire logic signed [ANG_W-1:0] basic_angle_i,
	input wire logic signed [ANG_W-1:0] current_angle_i,
	input wire logic [N_STAGES-1:0]     stage_start_i,
	input wire logic [N_STAGES-1:0]     stage_operate_i,
	input wire logic [TICK_LEN_W-1:0]   residual_stage_operate_time_i,
	input wire logic [TICK_LEN_W-1:0]   first_stage_operate_time_i,
	input wire logic [TICK_LEN_W-1:0]   second_stage_operate_time_i,
	input wire logic [1:0]              display_select_i,
	input wire logic [2:0]              register_select_i,
	input wire logic [2:0]              subregister_select_i,
	input wire logic                    panel_clear_i,
	input wire logic                    external_clear_i,
	input wire logic                    serial_clear_i,
	input wire logic                    supply_lost_i,
	input wire logic                    record_retention_switch_i,
	input wire logic [N_SW-1:0]         function_switch_group_one_i,
	input wire logic [3:0]              display_address_o,
	input wire logic [DISP_W-1:0]       display_value_o,
	input wire logic                    display_dash_o,
	input wire logic [2:0]              indicator_lamp_o,
	input wire logic [N_SW-1:0]         checksum_o
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	logic       up_ff;
	logic [3:0] calm_ff;

	function automatic logic [DISP_W-1:0] pct_of(
		input logic [MEAS_W-1:0] t,
		input logic [PCT_W-1:0]  span
	);
		logic [27:0] p;
		p = (28'(t) * 28'(DIV10_MUL)) >> DIV10_SHIFT;
		return (p > 28'(span)) ? DISP_W'(span) : DISP_W'(p);
	endfunction

	function automatic logic [DISP_W-1:0] fold(
		input logic signed [ANG_W-1:0] b,
		input logic signed [ANG_W-1:0] c
	);
		logic signed [DISP_W-1:0] d;
		d = DISP_W'(b) - DISP_W'(c);
		if (d > ANG_HALF)
			d = d - ANG_FULL;
		else if (d < -ANG_HALF)
			d = d + ANG_FULL;
		return d;
	endfunction

	// cycles of register view with nothing that may move the records
	always_ff @(posedge sys_clk_i) begin
		up_ff <= rst_n_i;
		if (!rst_n_i || display_select_i != SHOW_REG ||
				!$stable(register_select_i) ||
				!$stable(subregister_select_i) ||
				!$stable(stage_start_i) || !$stable(stage_operate_i) ||
				panel_clear_i || external_clear_i || serial_clear_i ||
				supply_lost_i)
			calm_ff <= 4'h0;
		else if (calm_ff != 4'hF)
			calm_ff <= calm_ff + 4'h1;
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	volt_view_a: assert property (
		up_ff && display_select_i == SHOW_VOLT |=> !display_dash_o &&
		indicator_lamp_o == LAMP_VOLT && display_value_o ==
		pct_of($past(residual_voltage_i), VOLT_SPAN_PCT))
		else $error("voltage view wrong");
	curr_view_a: assert property (
		up_ff && display_select_i == SHOW_CURR |=> !display_dash_o &&
		indicator_lamp_o == LAMP_CURR && display_value_o ==
		pct_of($past(neutral_current_i), CURR_SPAN_PCT))
		else $error("current view wrong");
	angle_value_a: assert property (
		up_ff && display_select_i == SHOW_ANG &&
		residual_voltage_i >= MIN_TENTHS &&
		neutral_current_i >= MIN_TENTHS |=> !display_dash_o &&
		indicator_lamp_o == LAMP_ANG && display_value_o ==
		fold($past(basic_angle_i), $past(current_angle_i)))
		else $error("angle view wrong");
	angle_dash_a: assert property (
		up_ff && display_select_i == SHOW_ANG &&
		(residual_voltage_i < MIN_TENTHS ||
		neutral_current_i < MIN_TENTHS) |=> display_dash_o)
		else $error("weak signal angle without dash");
	reg_address_a: assert property (
		up_ff && display_select_i == SHOW_REG &&
		register_select_i inside {[REG_VOLT:REG_LAST]} &&
		subregister_select_i <= 3'h4 |=> !display_dash_o &&
		indicator_lamp_o == LAMP_NONE &&
		display_address_o == {1'b0, $past(register_select_i)})
		else $error("register view address wrong");
	reg_refuse_a: assert property (
		up_ff && display_select_i == SHOW_REG &&
		(register_select_i == 3'h0 || register_select_i == 3'h7)
		|=> display_dash_o && display_value_o == '0)
		else $error("bad register shown");
	switch_sum_a: assert property (
		up_ff |=> checksum_o == $past(function_switch_group_one_i))
		else $error("checksum wrong");
	hist_hold_a: assert property (
		calm_ff >= 4'h4 |-> $stable(display_value_o))
		else $error("record moved with no commit");

	event_done_c: cover property ($fell(|stage_start_i));
	count_view_c: cover property (display_select_i == SHOW_REG &&
		subregister_select_i == SUB_COUNT);
	dash_shown_c: cover property (display_dash_o);
endmodule
bind earth_fault_event_recorder recorder_sva #(
	.TICK_LEN_W(TICK_LEN_W)
) chk (.*);
`default_nettype wire

/* test/stage_source.sv */
// model of the protection stages driving start and operate
`default_nettype none
module stage_source
	import recorder_pkg::*;
(
	input  wire logic                clk_i,
	output var  logic [N_STAGES-1:0] start_o,
	output var  logic [N_STAGES-1:0] operate_o
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		start_o = '0;
		operate_o = '0;
	end

	// start first, optional operate later, both drop together
	task automatic run_event(input int s, input int hold, input int op_at);
		@(posedge clk_i);
		start_o[s] <= 1'b1;
		for (int j = 1; j <= hold; j++) begin
			@(posedge clk_i);
			if (j == op_at)
				operate_o[s] <= 1'b1;
		end
		start_o <= '0;
		operate_o <= '0;
	endtask
endmodule
`default_nettype wire

/* test/test_earth_fault_event_recorder.sv */
// self-checking bench of the earth-fault event recorder
`default_nettype none
module test_earth_fault_event_recorder
	import recorder_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct {
		logic [1:0] sel;
		logic [2:0] rg;
		logic [11:0] v, c;
		logic [8:0] b, a;
		logic [7:0] sw;
		logic [9:0] val;
		logic dash;
		logic [2:0] lamp;
	} row_t;

	logic                    sys_clk_i = 1'b0;
	logic                    rst_n_i = 1'b0;
	logic [MEAS_W-1:0]       residual_voltage_i = '0;
	logic [MEAS_W-1:0]       neutral_current_i = '0;
	logic signed [ANG_W-1:0] basic_angle_i = '0;
	logic signed [ANG_W-1:0] current_angle_i = '0;
	logic [N_STAGES-1:0]     stage_start_i, stage_operate_i;
	logic [TICK_W-1:0]       residual_stage_operate_time_i = 16'h0002;
	logic [TICK_W-1:0]       first_stage_operate_time_i = 16'h0002;
	logic [TICK_W-1:0]       second_stage_operate_time_i = 16'h0003;
	logic [1:0]              display_select_i = '0;
	logic [2:0]              register_select_i = '0;
	logic [2:0]              subregister_select_i = '0;
	logic                    panel_clear_i = 1'b0, external_clear_i = 1'b0;
	logic                    serial_clear_i = 1'b0, supply_lost_i = 1'b0;
	logic                    record_retention_switch_i = 1'b0;
	logic [N_SW-1:0]         function_switch_group_one_i = '0;
	logic [3:0]              display_address_o;
	logic [DISP_W-1:0]       display_value_o;
	logic                    display_dash_o;
	logic [2:0]              indicator_lamp_o;
	logic [N_SW-1:0]         checksum_o;
	int                      err_total = 0;
	int                      n_checks = 0;
	row_t                    rows [9] = '{
		'{SHOW_VOLT, 3'h0, 12'h423, 12'h000, 9'h000, 9'h000,
			8'h45, 10'h069, 1'b0, 3'h1},
		'{SHOW_VOLT, 3'h0, 12'h4B0, 12'h000, 9'h000, 9'h000,
			8'hFF, 10'h06A, 1'b0, 3'h1},
		'{SHOW_CURR, 3'h0, 12'h000, 12'h9C4, 9'h000, 9'h000,
			8'h80, 10'h0D2, 1'b0, 3'h2},
		'{SHOW_CURR, 3'h0, 12'h000, 12'h3E8, 9'h000, 9'h000,
			8'h01, 10'h064, 1'b0, 3'h2},
		'{SHOW_ANG, 3'h0, 12'h032, 12'h032, 9'h000, 9'h1A6,
			8'h00, 10'h05A, 1'b0, 3'h4},
		'{SHOW_ANG, 3'h0, 12'h032, 12'h032, 9'h1A6, 9'h078,
			8'h10, 10'h096, 1'b0, 3'h4},
		'{SHOW_ANG, 3'h0, 12'h032, 12'h032, 9'h0AA, 9'h19C,
			8'h22, 10'h3A6, 1'b0, 3'h4},
		'{SHOW_ANG, 3'h0, 12'h002, 12'h032, 9'h000, 9'h1A6,
			8'h00, 10'h000, 1'b1, 3'h4},
		'{SHOW_REG, 3'h7, 12'h000, 12'h000, 9'h000, 9'h000,
			8'h00, 10'h000, 1'b1, 3'h0}
	};

	earth_fault_event_recorder dut (.*);
	stage_source src (
		.clk_i    (sys_clk_i),
		.start_o  (stage_start_i),
		.operate_o(stage_operate_i)
	);

	always #25 sys_clk_i = ~sys_clk_i;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [9:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic view(input logic [2:0] rg, sb);
		@(posedge sys_clk_i);
		display_select_i <= SHOW_REG;
		register_select_i <= rg;
		subregister_select_i <= sb;
		repeat (2) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		#1ms;
		err_total++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		@(negedge sys_clk_i);
		check("reset value", display_value_o, 10'h000);
		foreach (rows[i]) begin
			@(posedge sys_clk_i);
			display_select_i <= rows[i].sel;
			register_select_i <= rows[i].rg;
			residual_voltage_i <= rows[i].v;
			neutral_current_i <= rows[i].c;
			basic_angle_i <= rows[i].b;
			current_angle_i <= rows[i].a;
			function_switch_group_one_i <= rows[i].sw;
			repeat (2) @(posedge sys_clk_i);
			@(negedge sys_clk_i);
			check("value", display_value_o, rows[i].val);
			check("dash", display_dash_o, rows[i].dash);
			check("lamp", indicator_lamp_o, rows[i].lamp);
			check("checksum", checksum_o, rows[i].sw);
		end
		view(REG_CURR, 3'h0);
		check("address", display_address_o, 4'h2);
		@(posedge sys_clk_i);
		neutral_current_i <= 12'h1F4;
		for (int i = 0; i < 6; i++) begin
			@(posedge sys_clk_i);
			residual_voltage_i <= 12'(12'h064 * (i + 1));
			current_angle_i <= 9'h1A6;
			basic_angle_i <= 9'h000;
			fork
				src.run_event(1, 12, (i == 5) ? 6 : 0);
				begin
					repeat (6) @(posedge sys_clk_i);
					residual_voltage_i <= 12'h3E7;
				end
			join
			repeat (3) @(posedge sys_clk_i);
		end
		for (int k = 0; k < 5; k++) begin
			view(REG_VOLT, 3'(k));
			check("voltage record", display_value_o,
				(k == 0) ? 10'h063 : 10'(10'h00A * (6 - k)));
		end
		view(REG_CURR, 3'h0);
		check("current record", display_value_o, 10'h032);
		view(REG_ANG, 3'h0);
		check("angle record", display_value_o, 10'h05A);
		view(3'h5, 3'h0);
		check("operate duration", display_value_o, 10'h064);
		view(3'h5, 3'h1);
		check("partial duration", display_value_o < 10'h064, 1'b1);
		view(REG_DUR0, 3'h0);
		check("idle stage duration", display_value_o, 10'h000);
		view(3'h5, SUB_COUNT);
		check("first stage starts", display_value_o, 10'h006);
		for (int k = 0; k < 5; k++) begin
			@(posedge sys_clk_i);
			record_retention_switch_i <= (k == 4);
			src.run_event(0, 2, 0);
			repeat (3) @(posedge sys_clk_i);
			panel_clear_i <= (k == 0);
			external_clear_i <= (k == 1);
			serial_clear_i <= (k == 2);
			supply_lost_i <= (k >= 3);
			@(posedge sys_clk_i);
			{panel_clear_i, external_clear_i} <= 2'h0;
			{serial_clear_i, supply_lost_i} <= 2'h0;
			view(REG_VOLT, 3'h0);
			check("cleared record", display_value_o,
				(k == 4) ? 10'h063 : 10'h000);
		end
		@(posedge sys_clk_i);
		panel_clear_i <= 1'b1;
		@(posedge sys_clk_i);
		panel_clear_i <= 1'b0;
		for (int n = 1; n <= 257; n++) begin
			src.run_event(0, 1, 0);
			if (n == 3 || n == 257) begin
				view(REG_DUR0, SUB_COUNT);
				check("start count", display_value_o,
					(n == 3) ? 10'h003 : 10'h0FF);
			end
		end
		give_verdict();
	end
endmodule
`default_nettype wire
